// ==== dv/flash_lock_key_program_erase_tb_top.sv ====
/*
  Bench of the flash sequencer: core end and device end joined by the link,
  driven through the software port and the debug write port.
  Assumes shortened write and erase times.
*/
`timescale 1ns/1ps
`default_nettype none
`include "flk_defs.svh"

module flash_lock_key_program_erase_tb_top;
  localparam int WC = 8;
  localparam int EC = 600;
  logic        clock_i;
  logic        rst_i;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        dbg_wr;
  logic [15:0] dbg_addr;
  logic [7:0]  dbg_data;
  logic        dbg_busy;
  logic        dis;
  logic [7:0]  r;
  int          n_fail;
  int          checked;

  flk_if bus ();
  flk_core u_flk_core (.clock_i(clock_i), .rst_i(rst_i), .bus(bus.core),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata));
  flk_dev #(.WRITE_CYCLES(WC), .ERASE_CYCLES(EC)) u_flk_dev (.clock_i(clock_i),
    .rst_i(rst_i), .bus(bus.dev), .dbg_wr_i(dbg_wr), .dbg_addr_i(dbg_addr),
    .dbg_data_i(dbg_data), .dbg_busy_o(dbg_busy), .flash_disabled_o(dis));
  flk_chk #(.WC(WC), .EC(EC)) u_flk_chk (.clock_i(clock_i), .rst_i(rst_i),
    .sfr_wr(bus.sfr_wr), .sfr_rd(bus.sfr_rd), .sfr_addr(bus.sfr_addr),
    .xm_wr(bus.xm_wr), .xm_rd(bus.xm_rd), .cm_rd(bus.cm_rd),
    .mem_addr(bus.mem_addr), .wdata(bus.wdata), .rvalid(bus.rvalid),
    .stall(bus.stall));

  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  task automatic report_and_stop;
    if (n_fail == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock_i);
    reg_wr <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic rd_stat(output logic [15:0] s);
    reg_addr <= `FLK_CR_STAT;
    reg_rd <= 1'b1;
    @(posedge clock_i);
    reg_rd <= 1'b0;
    #1 s = reg_rdata;
    @(posedge clock_i);
  endtask

  // one link access, then polls until the core end is idle
  task automatic op(input flk_pkg::flk_cmd_t c, input logic [15:0] a, input logic [7:0] d);
    logic [15:0] s;
    int n;
    wr(`FLK_CR_ADDR, a);
    wr(`FLK_CR_DATA, {8'h00, d});
    wr(`FLK_CR_CMD, {13'h0000, c});
    s = 16'h0001;
    for (n = 0; n < 400 && s[0] !== 1'b0; n++) rd_stat(s);
    chk({7'h00, s[0]}, 8'h00);
    r = s[15:8];
  endtask

  task automatic get(input flk_pkg::flk_cmd_t c, input logic [15:0] a, input logic [7:0] e);
    op(c, a, 8'h00);
    chk(r, e);
  endtask

  task automatic sfr(input logic [7:0] a, input logic [7:0] d);
    op(flk_pkg::CMD_SFR_WR, {8'h00, a}, d);
  endtask

  task automatic key(input int gap);
    sfr(`FLK_SFR_KEY, `FLK_KEY_FIRST);
    repeat (gap) @(posedge clock_i);
    sfr(`FLK_SFR_KEY, `FLK_KEY_SECOND);
  endtask

  task automatic do_reset;
    rst_i <= 1'b1;
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic s_erase;
    sfr(`FLK_SFR_CTL, 8'h03);
    key(0);
    op(flk_pkg::CMD_XM_WR, 16'h0234, 8'h00);
    get(flk_pkg::CMD_CM_RD, 16'h0200, 8'hff);
    get(flk_pkg::CMD_CM_RD, 16'h03ff, 8'hff);
    get(flk_pkg::CMD_SFR_RD, {8'h00, `FLK_SFR_KEY}, 8'h00);
    get(flk_pkg::CMD_SFR_RD, {8'h00, `FLK_SFR_CTL}, 8'h03);
  endtask

  task automatic s_write;
    sfr(`FLK_SFR_CTL, 8'h01);
    key(40);
    op(flk_pkg::CMD_XM_WR, 16'h0210, 8'h5a);
    get(flk_pkg::CMD_CM_RD, 16'h0210, 8'h5a);
    key(0);
    op(flk_pkg::CMD_XM_WR, 16'h0210, 8'h0f);
    get(flk_pkg::CMD_CM_RD, 16'h0210, 8'h0a);
    op(flk_pkg::CMD_XM_WR, 16'h0211, 8'h00);
    chk({7'h00, dis}, 8'h01);
    get(flk_pkg::CMD_CM_RD, 16'h0211, 8'hff);
    key(0);
    op(flk_pkg::CMD_XM_WR, 16'h0211, 8'h00);
    get(flk_pkg::CMD_CM_RD, 16'h0211, 8'hff);
    do_reset;
    chk({7'h00, dis}, 8'h00);
  endtask

  task automatic s_ram;
    op(flk_pkg::CMD_XM_WR, 16'h0210, 8'h33);
    get(flk_pkg::CMD_XM_RD, 16'h0210, 8'h33);
    get(flk_pkg::CMD_CM_RD, 16'h0210, 8'h0a);
    sfr(`FLK_SFR_CTL, 8'h01);
    get(flk_pkg::CMD_XM_RD, 16'h0210, 8'h33);
    sfr(`FLK_SFR_CTL, 8'h00);
  endtask

  // repeated first code, second code first, foreign value
  task automatic s_bad;
    for (int i = 0; i < 3; i++) begin
      if (i == 0) sfr(`FLK_SFR_KEY, `FLK_KEY_FIRST);
      sfr(`FLK_SFR_KEY, i == 0 ? `FLK_KEY_FIRST : (i == 1 ? `FLK_KEY_SECOND : 8'h3c));
      chk({7'h00, dis}, 8'h01);
      get(flk_pkg::CMD_SFR_RD, {8'h00, `FLK_SFR_KEY}, 8'h03);
      do_reset;
    end
  endtask

  task automatic s_dbg;
    int n;
    dbg_addr <= 16'h0220;
    dbg_data <= 8'h3c;
    dbg_wr <= 1'b1;
    @(posedge clock_i);
    dbg_wr <= 1'b0;
    repeat (2) @(posedge clock_i);
    for (n = 0; n < 50 && dbg_busy !== 1'b0; n++) @(posedge clock_i);
    @(posedge clock_i);
    get(flk_pkg::CMD_CM_RD, 16'h0220, 8'h3c);
    get(flk_pkg::CMD_SFR_RD, {8'h00, `FLK_SFR_KEY}, 8'h00);
  endtask

  initial begin
    rst_i = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    dbg_wr = 1'b0;
    dbg_addr = 16'h0000;
    dbg_data = 8'h00;
    n_fail = 0;
    checked = 0;
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    s_erase;
    s_write;
    s_ram;
    s_bad;
    s_dbg;
    report_and_stop;
  end

  initial begin
    repeat (30000) @(posedge clock_i);
    n_fail++;
    report_and_stop;
  end
endmodule

`default_nettype wire

// ==== dv/flk_chk.sv ====
/*
  Checker of the core-to-flash link: strobes, read answers, stall length.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "flk_defs.svh"

module flk_chk #(
  parameter int WC = 8,
  parameter int EC = 600
) (
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic        sfr_wr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_addr,
  input wire logic        xm_wr,
  input wire logic        xm_rd,
  input wire logic        cm_rd,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0]  wdata,
  input wire logic        rvalid,
  input wire logic        stall
);
  logic [1:0]  ks_q;
  logic        we_q;
  logic        ee_q;
  logic        er_q;
  logic [19:0] cnt_q;
  logic        go;

  assign go = xm_wr && we_q && ks_q == 2'd2;

  // follows the key state as the device should
  always_ff @(posedge clock_i) begin
    if (rst_i) ks_q <= 2'd0;
    else if (sfr_wr && sfr_addr == `FLK_SFR_KEY) begin
      if (ks_q == 2'd0 && wdata == `FLK_KEY_FIRST) ks_q <= 2'd1;
      else if (ks_q == 2'd1 && wdata == `FLK_KEY_SECOND) ks_q <= 2'd2;
      else ks_q <= 2'd3;
    end else if (xm_wr && we_q && ks_q != 2'd3) ks_q <= go ? 2'd0 : 2'd3;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) {ee_q, we_q} <= 2'b00;
    else if (sfr_wr && sfr_addr == `FLK_SFR_CTL) {ee_q, we_q} <= wdata[1:0];
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) cnt_q <= '0;
    else cnt_q <= stall ? cnt_q + 20'h00001 : '0;
  end

  // remembers whether the running operation is an erase
  always_ff @(posedge clock_i) begin
    if (rst_i) er_q <= 1'b0;
    else er_q <= xm_wr ? (go && ee_q) : (stall && er_q);
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);

  sequence s_go;
    go;
  endsequence
  sequence s_run;
    stall ##1 stall;
  endsequence

  property p_start; s_go |=> s_run; endproperty
  property p_erase; s_go ##0 ee_q |=> stall [*8]; endproperty
  property p_refuse; xm_wr && !go |=> !stall; endproperty
  property p_len; $fell(stall) |-> cnt_q == (er_q ? EC : WC); endproperty
  property p_quiet; stall |-> !(sfr_wr || sfr_rd || xm_wr || xm_rd || cm_rd); endproperty
  property p_hold; stall && $past(stall) |-> $stable(mem_addr); endproperty
  property p_ans; sfr_rd || xm_rd || cm_rd |=> rvalid; endproperty
  property p_noans; rvalid |-> $past(sfr_rd || xm_rd || cm_rd); endproperty
  property p_one; $onehot0({sfr_wr, sfr_rd, xm_wr, xm_rd, cm_rd}); endproperty

  a_start: assert property (p_start)
    else $error("unlocked flash write did not stall");
  a_erase: assert property (p_erase)
    else $error("erase stall too short");
  a_refuse: assert property (p_refuse)
    else $error("refused write stalled the core");
  a_len: assert property (p_len)
    else $error("operation length wrong");
  a_quiet: assert property (p_quiet)
    else $error("request issued during stall");
  a_hold: assert property (p_hold)
    else $error("address moved during stall");
  a_ans: assert property (p_ans)
    else $error("read not answered");
  a_noans: assert property (p_noans)
    else $error("answer without read");
  a_one: assert property (p_one)
    else $error("two strobes at once");
endmodule

`default_nettype wire

// ==== inc/flk_defs.svh ====
/*
  Shared constants of the flash lock-and-key sequencer: special-register
  addresses, key codes, bit positions, memory sizes and operation timing.
  Assumes a 40 MHz system clock; included by its bare name.
*/
`ifndef FLK_DEFS_SVH
`define FLK_DEFS_SVH

// special-register addresses seen by the core
`define FLK_SFR_CTL        8'h8f
`define FLK_SFR_KEY        8'hb7

// key codes, in the order they must arrive
`define FLK_KEY_FIRST      8'ha5
`define FLK_KEY_SECOND     8'hf1

// program_store_control bit positions
`define FLK_CTL_WE         0
`define FLK_CTL_EE         1

`define FLK_ERASED         8'hff
`define FLK_ZERO_BYTE      8'h00

// memory sizes in bytes
`define FLK_PAGE_BYTES     512
`define FLK_FLASH_BYTES    16384
`define FLK_RAM_BYTES      1024

// timing: least times, rounded up to whole cycles
`define FLK_CLK_MHZ        40
`define FLK_WRITE_TIME_NS  20000
`define FLK_ERASE_TIME_NS  20000000
`define FLK_WRITE_CYCLES   ((`FLK_WRITE_TIME_NS * `FLK_CLK_MHZ + 999) / 1000)
`define FLK_ERASE_CYCLES   ((`FLK_ERASE_TIME_NS * `FLK_CLK_MHZ + 999) / 1000)

// software-port register indices of the core end
`define FLK_CR_ADDR        4'h0
`define FLK_CR_DATA        4'h1
`define FLK_CR_CMD         4'h2
`define FLK_CR_STAT        4'h3

// core status word layout
`define FLK_STAT_BUSY      0
`define FLK_STAT_LAST_LSB  8

`endif

// ==== inc/flk_if.sv ====
/*
  Link between the processor core and the flash sequencer: special-register
  accesses, external_space_move and code_space_move accesses, read answer
  and stall. Assumes both ends run on one clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface flk_if;
  logic        sfr_wr;
  logic        sfr_rd;
  logic [7:0]  sfr_addr;
  logic        xm_wr;
  logic        xm_rd;
  logic        cm_rd;
  logic [15:0] mem_addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        rvalid;
  logic        stall;

  modport dev (
    input  sfr_wr, sfr_rd, sfr_addr, xm_wr, xm_rd, cm_rd, mem_addr, wdata,
    output rdata, rvalid, stall
  );

  modport core (
    output sfr_wr, sfr_rd, sfr_addr, xm_wr, xm_rd, cm_rd, mem_addr, wdata,
    input  rdata, rvalid, stall
  );
endinterface

`default_nettype wire

// ==== inc/flk_pkg.sv ====
/*
  Types of the flash lock-and-key sequencer: key sequence state, flash
  operation state and core command codes. Assumes nothing outside it.
*/
package flk_pkg;

  typedef enum logic [1:0] {
    KEY_LOCKED,
    KEY_FIRST_SEEN,
    KEY_OPEN,
    KEY_DEAD
  } flk_key_t;

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_WRITE,
    OP_ERASE
  } flk_op_t;

  typedef enum logic [2:0] {
    CMD_SFR_WR,
    CMD_SFR_RD,
    CMD_XM_WR,
    CMD_XM_RD,
    CMD_CM_RD
  } flk_cmd_t;

endpackage

// ==== logic/flk_core.sv ====
/*
  Flash sequencer, core end: turns software-port commands into special-
  register accesses and external_space_move / code_space_move accesses,
  waits out stalls and read answers. Assumes the device answers every read
  one cycle after taking it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "flk_defs.svh"

module flk_core (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  flk_if.core              bus,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [15:0]      reg_rdata_o
);
  logic [15:0] addr_q;
  logic [7:0]  data_q;
  logic [7:0]  last_q;
  logic        sfr_wr_q;
  logic        sfr_rd_q;
  logic        xm_wr_q;
  logic        xm_rd_q;
  logic        cm_rd_q;
  logic        wait_q;
  logic [15:0] rdata_q;
  logic        busy;
  logic        cmd_go;

  assign busy   = sfr_wr_q | sfr_rd_q | xm_wr_q | xm_rd_q | cm_rd_q | wait_q | bus.stall;
  assign cmd_go = reg_wr_i & (reg_addr_i == `FLK_CR_CMD) & ~busy;

  // operands, frozen while an access is under way
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      addr_q <= 16'h0000;
      data_q <= 8'h00;
    end else if (reg_wr_i && !busy) begin
      if (reg_addr_i == `FLK_CR_ADDR) begin
        addr_q <= reg_wdata_i;
      end else if (reg_addr_i == `FLK_CR_DATA) begin
        data_q <= reg_wdata_i[7:0];
      end
    end
  end

  // one-cycle access strobes; none issued while stalled
  always_ff @(posedge clock_i) begin
    sfr_wr_q <= 1'b0;
    sfr_rd_q <= 1'b0;
    xm_wr_q  <= 1'b0;
    xm_rd_q  <= 1'b0;
    cm_rd_q  <= 1'b0;
    if (!rst_i && cmd_go) begin
      unique case (flk_pkg::flk_cmd_t'(reg_wdata_i[2:0]))
        flk_pkg::CMD_SFR_WR: sfr_wr_q <= 1'b1;
        flk_pkg::CMD_SFR_RD: sfr_rd_q <= 1'b1;
        flk_pkg::CMD_XM_WR:  xm_wr_q  <= 1'b1;
        flk_pkg::CMD_XM_RD:  xm_rd_q  <= 1'b1;
        flk_pkg::CMD_CM_RD:  cm_rd_q  <= 1'b1;
        default: begin
        end
      endcase
    end
  end

  // wait for the read answer and keep it
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wait_q <= 1'b0;
      last_q <= 8'h00;
    end else begin
      if (sfr_rd_q || xm_rd_q || cm_rd_q) begin
        wait_q <= 1'b1;
      end else if (bus.rvalid) begin
        wait_q <= 1'b0;
      end
      if (bus.rvalid) begin
        last_q <= bus.rdata;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_q <= 16'h0000;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        `FLK_CR_ADDR: rdata_q <= addr_q;
        `FLK_CR_DATA: rdata_q <= {8'h00, data_q};
        `FLK_CR_STAT: rdata_q <= {last_q, 7'h00, busy};
        default:      rdata_q <= 16'h0000;
      endcase
    end
  end

  assign bus.sfr_wr   = sfr_wr_q;
  assign bus.sfr_rd   = sfr_rd_q;
  assign bus.xm_wr    = xm_wr_q;
  assign bus.xm_rd    = xm_rd_q;
  assign bus.cm_rd    = cm_rd_q;
  assign bus.sfr_addr = addr_q[7:0];
  assign bus.mem_addr = addr_q;
  assign bus.wdata    = data_q;
  assign reg_rdata_o  = rdata_q;
endmodule

`default_nettype wire

// ==== logic/flk_dev.sv ====
/*
  Flash sequencer, device end: program_store_control and flash_key_register,
  lock-and-key state, byte write and page erase of the flash array, routing
  of external_space_move accesses, core stall and the two_wire_debug_port
  byte write path. Holds the flash and external_data_ram arrays itself.
  Assumes the core issues nothing while stall is high and one access a cycle.
*/
// Operation
// - one byte per write, core or debug
// - write only clears bits: old AND new
// - hardware times every write and erase
// - core stalled while operation runs
// - key codes a5 then f1 unlock
// - no time limit between key steps
// - wrong or misordered code disables until reset
// - flash write while locked also disables
// - relock after each operation, rekey needed
// - write enable routes move writes to flash
// - write enable changed only by software
// - page erase sets page to ff
// - erase plus write enable erases page
// - write enable alone programs one byte
// - software rekeys for every byte
// - software clears write enable when done
// - move reads hit ram; code reads flash
// - blank part programmed by debug port
// - erase needs both enable bits set
`timescale 1ns/1ps
`default_nettype none
`include "flk_defs.svh"

module flk_dev #(
  parameter int FLASH_BYTES  = `FLK_FLASH_BYTES,
  parameter int PAGE_BYTES   = `FLK_PAGE_BYTES,
  parameter int RAM_BYTES    = `FLK_RAM_BYTES,
  parameter int WRITE_CYCLES = `FLK_WRITE_CYCLES,
  parameter int ERASE_CYCLES = `FLK_ERASE_CYCLES
) (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  flk_if.dev               bus,
  input  wire logic        dbg_wr_i,
  input  wire logic [15:0] dbg_addr_i,
  input  wire logic [7:0]  dbg_data_i,
  output logic             dbg_busy_o,
  output logic             flash_disabled_o
);
  localparam int FA = $clog2(FLASH_BYTES);
  localparam int PA = $clog2(PAGE_BYTES);
  localparam int XA = $clog2(RAM_BYTES);
  localparam int TW = $clog2(ERASE_CYCLES + 1);

  logic [7:0]        flash_mem [FLASH_BYTES];
  logic [7:0]        ram_mem   [RAM_BYTES];

  logic              we_q;
  logic              ee_q;
  flk_pkg::flk_key_t key_q;
  flk_pkg::flk_op_t  op_q;
  logic [FA-1:0]     op_addr_q;
  logic [7:0]        op_data_q;
  logic [PA:0]       sweep_q;
  logic              stall_q;
  logic              disabled_q;
  logic [7:0]        rdata_q;
  logic              rvalid_q;

  logic              idle;
  logic              fl_wr;
  logic              core_go;
  logic              dbg_go;
  logic              tmr_start;
  logic [TW-1:0]     tmr_len;
  logic              tmr_done;

  assign idle = (op_q == flk_pkg::OP_IDLE);
  assign fl_wr = bus.xm_wr & we_q;
  assign core_go = fl_wr & idle & (key_q == flk_pkg::KEY_OPEN);
  assign dbg_go = dbg_wr_i & idle & ~core_go;
  assign tmr_start = core_go | dbg_go;
  assign tmr_len = (core_go & ee_q) ? TW'(ERASE_CYCLES) : TW'(WRITE_CYCLES);

  flk_timer #(
    .W (TW)
  ) u_timer (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .start_i (tmr_start),
    .len_i   (tmr_len),
    .busy_o  (),
    .done_o  (tmr_done)
  );

  // enables move only on software write
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      we_q <= 1'b0;
      ee_q <= 1'b0;
    end else if (bus.sfr_wr && bus.sfr_addr == `FLK_SFR_CTL) begin
      we_q <= bus.wdata[`FLK_CTL_WE];
      ee_q <= bus.wdata[`FLK_CTL_EE];
    end
  end

  // key sequence; the dead state is left only by reset
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      key_q <= flk_pkg::KEY_LOCKED;
    end else if (bus.sfr_wr && bus.sfr_addr == `FLK_SFR_KEY) begin
      unique case (key_q)
        flk_pkg::KEY_LOCKED: begin
          key_q <= (bus.wdata == `FLK_KEY_FIRST) ? flk_pkg::KEY_FIRST_SEEN
                                                 : flk_pkg::KEY_DEAD;
        end
        flk_pkg::KEY_FIRST_SEEN: begin
          key_q <= (bus.wdata == `FLK_KEY_SECOND) ? flk_pkg::KEY_OPEN
                                                  : flk_pkg::KEY_DEAD;
        end
        flk_pkg::KEY_OPEN: begin
          key_q <= flk_pkg::KEY_DEAD;
        end
        flk_pkg::KEY_DEAD: begin
          key_q <= flk_pkg::KEY_DEAD;
        end
      endcase
    end else if (fl_wr) begin
      key_q <= (key_q == flk_pkg::KEY_OPEN && idle) ? flk_pkg::KEY_LOCKED
                                                    : flk_pkg::KEY_DEAD;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      disabled_q <= 1'b0;
    end else begin
      disabled_q <= (key_q == flk_pkg::KEY_DEAD);
    end
  end

  // operation state and its operands
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      op_q      <= flk_pkg::OP_IDLE;
      op_addr_q <= '0;
      op_data_q <= `FLK_ZERO_BYTE;
    end else if (core_go) begin
      op_q      <= ee_q ? flk_pkg::OP_ERASE : flk_pkg::OP_WRITE;
      op_addr_q <= bus.mem_addr[FA-1:0];
      op_data_q <= bus.wdata;
    end else if (dbg_go) begin
      op_q      <= flk_pkg::OP_WRITE;
      op_addr_q <= dbg_addr_i[FA-1:0];
      op_data_q <= dbg_data_i;
    end else if (tmr_done) begin
      op_q <= flk_pkg::OP_IDLE;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      stall_q <= 1'b0;
    end else if (tmr_start) begin
      stall_q <= 1'b1;
    end else if (tmr_done) begin
      stall_q <= 1'b0;
    end
  end

  // erase sweep index, one byte a cycle from the page base
  always_ff @(posedge clock_i) begin
    if (rst_i || tmr_start) begin
      sweep_q <= '0;
    end else if (op_q == flk_pkg::OP_ERASE && sweep_q != (PA+1)'(PAGE_BYTES)) begin
      sweep_q <= sweep_q + (PA+1)'(1);
    end
  end

  // flash array; no reset, contents are non-volatile
  always_ff @(posedge clock_i) begin
    if (op_q == flk_pkg::OP_ERASE && sweep_q != (PA+1)'(PAGE_BYTES)) begin
      flash_mem[{op_addr_q[FA-1:PA], sweep_q[PA-1:0]}] <= `FLK_ERASED;
    end else if (op_q == flk_pkg::OP_WRITE && tmr_done) begin
      flash_mem[op_addr_q] <= flash_mem[op_addr_q] & op_data_q;
    end
  end

  // blocked flash writes skip ram too
  always_ff @(posedge clock_i) begin
    if (bus.xm_wr && !we_q) begin
      ram_mem[bus.mem_addr[XA-1:0]] <= bus.wdata;
    end
  end

  // read answers, one cycle after the request
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_q  <= `FLK_ZERO_BYTE;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= bus.xm_rd | bus.cm_rd | bus.sfr_rd;
      if (bus.xm_rd) begin
        rdata_q <= ram_mem[bus.mem_addr[XA-1:0]];
      end else if (bus.cm_rd) begin
        rdata_q <= flash_mem[bus.mem_addr[FA-1:0]];
      end else if (bus.sfr_rd) begin
        if (bus.sfr_addr == `FLK_SFR_CTL) begin
          rdata_q <= {6'h00, ee_q, we_q};
        end else if (bus.sfr_addr == `FLK_SFR_KEY) begin
          rdata_q <= {6'h00, key_q};
        end else begin
          rdata_q <= `FLK_ZERO_BYTE;
        end
      end
    end
  end

  assign bus.stall        = stall_q;
  assign bus.rdata        = rdata_q;
  assign bus.rvalid       = rvalid_q;
  assign dbg_busy_o       = stall_q;
  assign flash_disabled_o = disabled_q;
endmodule

`default_nettype wire

// ==== logic/flk_timer.sv ====
/*
  Operation timer: on start it stays busy for len_i cycles and pulses done
  in the last one. Assumes start_i is only raised while idle.
*/
`timescale 1ns/1ps
`default_nettype none

module flk_timer #(
  parameter int W = 20
) (
  input  wire logic         clock_i,
  input  wire logic         rst_i,
  input  wire logic         start_i,
  input  wire logic [W-1:0] len_i,
  output logic              busy_o,
  output logic              done_o
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (start_i) begin
      cnt_q <= len_i;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  assign busy_o = (cnt_q != '0);
  assign done_o = (cnt_q == W'(1));
endmodule

`default_nettype wire
